// File: logic/hbw_pkg.sv
package hbw_pkg;
    // ========================================
    // sizes
    localparam int NUM_CORES = 8;
    localparam int NUM_UNITS = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SCRATCH_WORDS = 8;

    // ========================================
    // register offsets (printed index, used directly as address)
    localparam logic [7:0] OFS_STOP = 8'h18;
    localparam logic [7:0] OFS_SCR = 8'h20;
    localparam logic [7:0] OFS_IBA = 8'h30;
    localparam logic [7:0] OFS_IBC = 8'h40;
    localparam logic [7:0] OFS_DWA = 8'h50;
    localparam logic [7:0] OFS_DWB = 8'h60;
    localparam logic [7:0] OFS_DWC = 8'h70;
    localparam logic [7:0] OFS_RWM = 8'h80;
    localparam logic [7:0] OFS_RWV = 8'h90;
    localparam logic [7:0] OFS_RWC = 8'h9c;

    // ========================================
    // control field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_INV_BIT = 1;
    localparam int CTL_LOAD_BIT = 2;
    localparam int CTL_CORE_LSB = 16;
    localparam int STOP_LSB = 0;

    // ========================================
    // cause codes of the debug interrupt
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_IBRK = 3'h3,
        CAUSE_DWATCH = 3'h4,
        CAUSE_RWATCH = 3'h5
    } hbw_cause_type;

    typedef struct packed {
        logic [7:0] cores;
        logic load;
        logic inv;
        logic en;
    } hbw_ctl_type;

    // ========================================
    // values after reset
    localparam hbw_ctl_type RST_CTL = 11'h000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_STOP = 8'h00;
endpackage

// File: logic/hbw_scratch_mem.sv
module hbw_scratch_mem #(
    parameter int WORDS = 8,
    parameter int WIDTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [$clog2(WORDS)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_re,
    input wire logic [$clog2(WORDS)-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    typedef struct packed {
        logic [WORDS-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } hbw_mem_type;

    hbw_mem_type st_r;
    hbw_mem_type st_nxt;

    // ========================================
    // read before write: same-cycle write is seen on the next read
    always_comb begin
        st_nxt = st_r;
        if (i_re) begin
            st_nxt.rdata = st_r.mem[i_raddr];
        end
        if (i_we) begin
            st_nxt.mem[i_waddr] = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
endmodule

// File: logic/hbw_unit.sv
// Design decision made here: strobed register access.
module hbw_unit (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR_EN,
    input wire logic I_RD_EN,
    output logic [31:0] O_RDATA,
    input wire logic I_DBG_MODE,
    input wire logic I_EXEC_VALID,
    input wire logic [2:0] I_EXEC_CORE,
    input wire logic [31:0] I_EXEC_PC,
    input wire logic I_MEM_VALID,
    input wire logic I_MEM_LOAD,
    input wire logic [2:0] I_MEM_CORE,
    input wire logic [31:0] I_MEM_ADDR,
    input wire logic I_RES_VALID,
    input wire logic [2:0] I_RES_CORE,
    input wire logic [31:0] I_RES_ID,
    output logic [7:0] O_CORE_RUN_EN,
    output logic O_DBG_IRQ,
    output logic [2:0] O_DBG_CAUSE,
    output logic [1:0] O_DBG_UNIT,
    output logic [31:0] O_DBG_DATA
);
    typedef struct packed {
        logic [7:0] stop;
        logic [3:0][31:0] iba;
        hbw_pkg::hbw_ctl_type [3:0] ibc;
        logic [3:0][31:0] dwa;
        logic [3:0][31:0] dwb;
        hbw_pkg::hbw_ctl_type [3:0] dwc;
        logic [3:0][31:0] rwm;
        logic [3:0][31:0] rwv;
        hbw_pkg::hbw_ctl_type [3:0] rwc;
        logic [31:0] rdata;
        logic scr_rd;
        logic irq;
        hbw_pkg::hbw_cause_type cause;
        logic [1:0] unit;
        logic [31:0] data;
    } hbw_state_type;

    hbw_state_type st_r;
    hbw_state_type st_nxt;
    logic [31:0] scr_rdata;
    logic [3:0] hit_ib;
    logic [3:0] hit_dw;
    logic [3:0] hit_rw;
    logic [7:0] base;
    logic [1:0] idx;
    logic is_scr;

    // ========================================
    // helpers
    function automatic hbw_pkg::hbw_ctl_type ctl_wr(input logic [31:0] w, input logic has_load);
        hbw_pkg::hbw_ctl_type c;
        c.cores = w[hbw_pkg::CTL_CORE_LSB +: 8];
        c.load = has_load & w[hbw_pkg::CTL_LOAD_BIT];
        c.inv = w[hbw_pkg::CTL_INV_BIT];
        c.en = w[hbw_pkg::CTL_EN_BIT];
        return c;
    endfunction

    function automatic logic [31:0] ctl_rd(input hbw_pkg::hbw_ctl_type c);
        logic [31:0] w;
        w = hbw_pkg::RST_WORD;
        w[hbw_pkg::CTL_CORE_LSB +: 8] = c.cores;
        w[hbw_pkg::CTL_LOAD_BIT] = c.load;
        w[hbw_pkg::CTL_INV_BIT] = c.inv;
        w[hbw_pkg::CTL_EN_BIT] = c.en;
        return w;
    endfunction

    // unit armed for this core; a clear enable bit or core bit blocks it
    function automatic logic armed(input hbw_pkg::hbw_ctl_type c, input logic [2:0] core);
        return c.en & c.cores[core];
    endfunction

    function automatic logic [1:0] lowest(input logic [3:0] h);
        logic [1:0] n;
        n = 2'h0;
        for (int k = 3; k >= 0; k--) begin
            if (h[k]) begin
                n = k[1:0];
            end
        end
        return n;
    endfunction

    assign base = {I_ADDR[7:2], 2'h0};
    assign idx = I_ADDR[1:0];
    assign is_scr = (I_ADDR[7:3] == hbw_pkg::OFS_SCR[7:3]);

    // ========================================
    // scratch words
    // scratch word storage
    hbw_scratch_mem #(
        .WORDS(hbw_pkg::SCRATCH_WORDS),
        .WIDTH(hbw_pkg::DATA_W)
    ) u_scratch (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_we(I_WR_EN & is_scr),
        .i_waddr(I_ADDR[2:0]),
        .i_wdata(I_WDATA),
        .i_re(I_RD_EN & is_scr),
        .i_raddr(I_ADDR[2:0]),
        .o_rdata(scr_rdata)
    );

    // ========================================
    // comparators
    always_comb begin
        for (int i = 0; i < hbw_pkg::NUM_UNITS; i++) begin
            hit_ib[i] = I_EXEC_VALID & armed(st_r.ibc[i], I_EXEC_CORE)
                & ((I_EXEC_PC == st_r.iba[i]) ^ st_r.ibc[i].inv);
            // loads only with load bit; stores always
            hit_dw[i] = I_MEM_VALID & armed(st_r.dwc[i], I_MEM_CORE)
                & (~I_MEM_LOAD | st_r.dwc[i].load)
                & (st_r.dwc[i].inv
                   ? !((I_MEM_ADDR > st_r.dwb[i]) && (I_MEM_ADDR < st_r.dwa[i]))
                   : ((I_MEM_ADDR >= st_r.dwa[i]) && (I_MEM_ADDR <= st_r.dwb[i])));
            hit_rw[i] = I_RES_VALID & armed(st_r.rwc[i], I_RES_CORE)
                & (((I_RES_ID & st_r.rwm[i]) == st_r.rwv[i]) ^ st_r.rwc[i].inv);
        end
    end

    // ========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.scr_rd = I_RD_EN & is_scr;
        // register writes
        if (I_WR_EN) begin
            unique case (base)
                hbw_pkg::OFS_STOP: begin
                    if (idx == 2'h0) begin
                        st_nxt.stop = I_WDATA[hbw_pkg::STOP_LSB +: 8];
                    end
                end
                hbw_pkg::OFS_IBA: st_nxt.iba[idx] = I_WDATA;
                hbw_pkg::OFS_IBC: st_nxt.ibc[idx] = ctl_wr(I_WDATA, 1'b0);
                hbw_pkg::OFS_DWA: st_nxt.dwa[idx] = I_WDATA;
                hbw_pkg::OFS_DWB: st_nxt.dwb[idx] = I_WDATA;
                hbw_pkg::OFS_DWC: st_nxt.dwc[idx] = ctl_wr(I_WDATA, 1'b1);
                hbw_pkg::OFS_RWM: st_nxt.rwm[idx] = I_WDATA;
                hbw_pkg::OFS_RWV: st_nxt.rwv[idx] = I_WDATA;
                hbw_pkg::OFS_RWC: st_nxt.rwc[idx] = ctl_wr(I_WDATA, 1'b0);
                default: ;
            endcase
        end
        // register reads; unmapped reads return zero
        st_nxt.rdata = hbw_pkg::RST_WORD;
        if (I_RD_EN) begin
            unique case (base)
                hbw_pkg::OFS_STOP: begin
                    if (idx == 2'h0) begin
                        st_nxt.rdata[hbw_pkg::STOP_LSB +: 8] = st_r.stop;
                    end
                end
                hbw_pkg::OFS_IBA: st_nxt.rdata = st_r.iba[idx];
                hbw_pkg::OFS_IBC: st_nxt.rdata = ctl_rd(st_r.ibc[idx]);
                hbw_pkg::OFS_DWA: st_nxt.rdata = st_r.dwa[idx];
                hbw_pkg::OFS_DWB: st_nxt.rdata = st_r.dwb[idx];
                hbw_pkg::OFS_DWC: st_nxt.rdata = ctl_rd(st_r.dwc[idx]);
                hbw_pkg::OFS_RWM: st_nxt.rdata = st_r.rwm[idx];
                hbw_pkg::OFS_RWV: st_nxt.rdata = st_r.rwv[idx];
                hbw_pkg::OFS_RWC: st_nxt.rdata = ctl_rd(st_r.rwc[idx]);
                default: ;
            endcase
        end
        // one request; no new hits while already in debug mode
        if (!I_DBG_MODE) begin
            // lowest unit wins; instruction before data before resource
            if (|hit_ib) begin
                st_nxt.irq = 1'b1;
                st_nxt.cause = hbw_pkg::CAUSE_IBRK;
                st_nxt.unit = lowest(hit_ib);
                st_nxt.data = I_EXEC_PC;
            end else if (|hit_dw) begin
                st_nxt.irq = 1'b1;
                st_nxt.cause = hbw_pkg::CAUSE_DWATCH;
                st_nxt.unit = lowest(hit_dw);
                st_nxt.data = I_MEM_ADDR;
            end else if (|hit_rw) begin
                st_nxt.irq = 1'b1;
                st_nxt.cause = hbw_pkg::CAUSE_RWATCH;
                st_nxt.unit = lowest(hit_rw);
                st_nxt.data = I_RES_ID;
            end
        end
    end

    // ========================================
    // state register
    // enables and core fields reset to zero
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            st_r <= '0;
            st_r.stop <= hbw_pkg::RST_STOP;
            st_r.ibc <= {4{hbw_pkg::RST_CTL}};
            st_r.dwc <= {4{hbw_pkg::RST_CTL}};
            st_r.rwc <= {4{hbw_pkg::RST_CTL}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // outputs
    // stopped cores held whenever out of debug mode
    // same mask keeps them halted after debug return
    assign O_CORE_RUN_EN = I_DBG_MODE ? 8'h00 : ~st_r.stop;
    assign O_RDATA = st_r.scr_rd ? scr_rdata : st_r.rdata;
    assign O_DBG_IRQ = st_r.irq;
    assign O_DBG_CAUSE = st_r.cause;
    assign O_DBG_UNIT = st_r.unit;
    assign O_DBG_DATA = st_r.data;

    // ========================================
    // checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    sequence s_stop_wr;
        I_WR_EN && I_ADDR == hbw_pkg::OFS_STOP;
    endsequence

    property p_stop_mask;
        s_stop_wr ##1 !I_DBG_MODE |-> O_CORE_RUN_EN == ~$past(I_WDATA[7:0]);
    endproperty
    a_stop_mask: assert property (p_stop_mask)
        else $error("stop mask not applied to core run enables");

    property p_debug_return;
        $fell(I_DBG_MODE) |-> (O_CORE_RUN_EN & st_r.stop) == 8'h00;
    endproperty
    a_debug_return: assert property (p_debug_return)
        else $error("stopped core resumed after debug return");

    sequence s_scr_wr;
        I_WR_EN && is_scr;
    endsequence

    sequence s_scr_rd_same;
        I_RD_EN && I_ADDR == $past(I_ADDR) && !I_WR_EN;
    endsequence

    property p_scratch;
        s_scr_wr ##1 s_scr_rd_same |=> O_RDATA == $past(I_WDATA, 2);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch word read back wrong");

    property p_ibrk0;
        I_EXEC_VALID && !I_DBG_MODE && armed(st_r.ibc[0], I_EXEC_CORE)
            && !st_r.ibc[0].inv && I_EXEC_PC == st_r.iba[0]
        |=> O_DBG_IRQ && O_DBG_CAUSE == 3'h3 && O_DBG_UNIT == 2'h0;
    endproperty
    a_ibrk0: assert property (p_ibrk0)
        else $error("instruction breakpoint 0 did not fire");

    property p_all_off;
        !st_r.ibc[0].en && !st_r.ibc[1].en && !st_r.ibc[2].en && !st_r.ibc[3].en
            && !I_MEM_VALID && !I_RES_VALID |=> !O_DBG_IRQ;
    endproperty
    a_all_off: assert property (p_all_off)
        else $error("disabled breakpoint fired");

    property p_dw_incl;
        I_MEM_VALID && !I_MEM_LOAD && !I_EXEC_VALID && !I_DBG_MODE
            && armed(st_r.dwc[0], I_MEM_CORE) && !st_r.dwc[0].inv
            && I_MEM_ADDR == st_r.dwb[0] && st_r.dwa[0] <= st_r.dwb[0]
        |=> O_DBG_IRQ && O_DBG_CAUSE == 3'h4 && O_DBG_DATA == $past(I_MEM_ADDR);
    endproperty
    a_dw_incl: assert property (p_dw_incl)
        else $error("store at upper bound missed");

    property p_load_off;
        I_MEM_VALID && I_MEM_LOAD && !I_EXEC_VALID && !I_RES_VALID
            && !st_r.dwc[0].load && !st_r.dwc[1].load
            && !st_r.dwc[2].load && !st_r.dwc[3].load |=> !O_DBG_IRQ;
    endproperty
    a_load_off: assert property (p_load_off)
        else $error("load watched with load bit clear");

    property p_rw0;
        I_RES_VALID && !I_EXEC_VALID && !I_MEM_VALID && !I_DBG_MODE
            && armed(st_r.rwc[0], I_RES_CORE)
            && (((I_RES_ID & st_r.rwm[0]) == st_r.rwv[0]) != st_r.rwc[0].inv)
        |=> O_DBG_IRQ && O_DBG_CAUSE == 3'h5 && O_DBG_DATA == $past(I_RES_ID);
    endproperty
    a_rw0: assert property (p_rw0)
        else $error("resource watchpoint 0 did not fire");

    property p_core_gate;
        I_EXEC_VALID && !I_MEM_VALID && !I_RES_VALID
            && !st_r.ibc[0].cores[I_EXEC_CORE] && !st_r.ibc[1].cores[I_EXEC_CORE]
            && !st_r.ibc[2].cores[I_EXEC_CORE] && !st_r.ibc[3].cores[I_EXEC_CORE]
        |=> !O_DBG_IRQ;
    endproperty
    a_core_gate: assert property (p_core_gate)
        else $error("breakpoint fired for a core not enabled");

    property p_ctl_rsvd;
        I_RD_EN && base == hbw_pkg::OFS_IBC
        |=> O_RDATA[31:24] == 8'h00 && O_RDATA[15:2] == 14'h0000;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd)
        else $error("reserved control bits not zero");
endmodule

// File: dv/hbw_pipe_model.sv
module hbw_pipe_model (
    input wire logic i_clk,
    output logic o_exec_valid,
    output logic [2:0] o_exec_core,
    output logic [31:0] o_exec_pc,
    output logic o_mem_valid,
    output logic o_mem_load,
    output logic [2:0] o_mem_core,
    output logic [31:0] o_mem_addr,
    output logic o_res_valid,
    output logic [2:0] o_res_core,
    output logic [31:0] o_res_id
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {o_exec_valid, o_exec_core, o_exec_pc} = '0;
        {o_mem_valid, o_mem_load, o_mem_core, o_mem_addr} = '0;
        {o_res_valid, o_res_core, o_res_id} = '0;
    end

    // ========================================
    // one pipeline event
    // data lines are inverted and valids cleared once released, so a stale value never looks like a repeat
    task automatic issue(input logic [2:0] kind, input logic [2:0] core, input logic [31:0] val,
                         input logic load);
        @(posedge i_clk);
        o_exec_valid <= kind[0];
        o_mem_valid <= kind[1];
        o_res_valid <= kind[2];
        {o_exec_core, o_mem_core, o_res_core} <= {core, core, core};
        {o_exec_pc, o_mem_addr, o_res_id} <= {val, val, val};
        o_mem_load <= load;
        @(posedge i_clk);
        {o_exec_valid, o_mem_valid, o_res_valid} <= 3'h0;
        {o_exec_core, o_mem_core, o_res_core} <= {~core, ~core, ~core};
        {o_exec_pc, o_mem_addr, o_res_id} <= {~val, ~val, ~val};
        o_mem_load <= ~load;
    endtask
endmodule

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic I_CLK = 1'b0;
    logic I_SYS_RST = 1'b1;
    logic [7:0] I_ADDR = 8'h00;
    logic [31:0] I_WDATA = 32'h0;
    logic I_WR_EN = 1'b0;
    logic I_RD_EN = 1'b0;
    logic I_DBG_MODE = 1'b0;
    logic [31:0] O_RDATA, I_EXEC_PC, I_MEM_ADDR, I_RES_ID, O_DBG_DATA;
    logic [2:0] I_EXEC_CORE, I_MEM_CORE, I_RES_CORE, O_DBG_CAUSE;
    logic I_EXEC_VALID, I_MEM_VALID, I_MEM_LOAD, I_RES_VALID, O_DBG_IRQ;
    logic [7:0] O_CORE_RUN_EN;
    logic [1:0] O_DBG_UNIT;
    int err_count = 0;
    int samples_checked = 0;
    logic [31:0] seed;
    logic [31:0] rq[$];
    logic [36:0] iq[$];
    logic rd_d = 1'b0;
    logic [7:0] regs[16] = '{8'h18, 8'h20, 8'h27, 8'h30, 8'h33, 8'h40, 8'h43, 8'h50,
                             8'h63, 8'h70, 8'h80, 8'h93, 8'h9c, 8'h9f, 8'h19, 8'ha0};
    logic [31:0] da[5] = '{32'h0fff, 32'h1000, 32'h1001, 32'h1fff, 32'h2000};
    logic [4:0] dexp[4] = '{5'b01110, 5'b00000, 5'b01110, 5'b11011};
    logic [31:0] d, pc, mk;
    logic [2:0] c;

    always #2 I_CLK = ~I_CLK;

    hbw_pipe_model pipe (.i_clk(I_CLK), .o_exec_valid(I_EXEC_VALID), .o_exec_core(I_EXEC_CORE),
        .o_exec_pc(I_EXEC_PC), .o_mem_valid(I_MEM_VALID), .o_mem_load(I_MEM_LOAD),
        .o_mem_core(I_MEM_CORE), .o_mem_addr(I_MEM_ADDR), .o_res_valid(I_RES_VALID),
        .o_res_core(I_RES_CORE), .o_res_id(I_RES_ID));

    hbw_unit dut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR_EN(I_WR_EN), .I_RD_EN(I_RD_EN), .O_RDATA(O_RDATA), .I_DBG_MODE(I_DBG_MODE),
        .I_EXEC_VALID(I_EXEC_VALID), .I_EXEC_CORE(I_EXEC_CORE), .I_EXEC_PC(I_EXEC_PC),
        .I_MEM_VALID(I_MEM_VALID), .I_MEM_LOAD(I_MEM_LOAD), .I_MEM_CORE(I_MEM_CORE),
        .I_MEM_ADDR(I_MEM_ADDR), .I_RES_VALID(I_RES_VALID), .I_RES_CORE(I_RES_CORE),
        .I_RES_ID(I_RES_ID), .O_CORE_RUN_EN(O_CORE_RUN_EN), .O_DBG_IRQ(O_DBG_IRQ),
        .O_DBG_CAUSE(O_DBG_CAUSE), .O_DBG_UNIT(O_DBG_UNIT), .O_DBG_DATA(O_DBG_DATA));

    // ========================================
    // comparison and verdict
    task automatic note(input string n, input logic [39:0] e, input logic [39:0] s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
        note("read data", {8'h00, e}, {8'h00, s});
    endtask
    task automatic chk_irq(input logic [36:0] e, input logic [36:0] s);
        note("debug request", {3'h0, e}, {3'h0, s});
    endtask
    task automatic chk_run(input logic [7:0] e);
        note("core run enable", {32'h0, e}, {32'h0, O_CORE_RUN_EN});
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ========================================
    // result watcher, oldest note first
    always @(posedge I_CLK) begin
        if (rd_d) chk_rd(rq.pop_front(), O_RDATA);
        if (O_DBG_IRQ === 1'b1) begin
            if (iq.size() == 0) note("unexpected request", 40'h0, 40'h1);
            else chk_irq(iq.pop_front(), {O_DBG_CAUSE, O_DBG_UNIT, O_DBG_DATA});
        end
        rd_d <= I_RD_EN;
    end

    // ========================================
    // bus and pipeline stimulus
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge I_CLK);
        {I_WR_EN, I_ADDR, I_WDATA} <= {1'b1, a, v};
        @(posedge I_CLK);
        {I_WR_EN, I_ADDR, I_WDATA} <= {1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge I_CLK);
        {I_RD_EN, I_ADDR} <= {1'b1, a};
        @(posedge I_CLK);
        {I_RD_EN, I_ADDR} <= {1'b0, ~a};
    endtask
    task automatic hit(input logic [2:0] k, input logic [2:0] cr, input logic [31:0] v,
                       input logic ld, input logic on, input logic [2:0] cs,
                       input logic [1:0] un);
        if (on) iq.push_back({cs, un, v});
        pipe.issue(k, cr, v, ld);
        repeat (2) @(posedge I_CLK);
    endtask
    task automatic do_reset;
        I_SYS_RST <= 1'b1;
        repeat (4) @(posedge I_CLK);
        I_SYS_RST <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [7:0] cr, input logic ld, inv, en);
        return {8'h00, cr, 13'h0000, ld, inv, en};
    endfunction
    // reserved bits read zero, unmapped places read zero
    function automatic logic [31:0] rmask(input logic [7:0] a);
        if (a == 8'h18) return 32'h0000_00ff;
        if (a == 8'h19 || a == 8'ha0) return 32'h0;
        if (a[7:4] == 4'h4 || a[7:2] == 6'h27) return 32'h00ff_0003;
        if (a[7:4] == 4'h7) return 32'h00ff_0007;
        return 32'hffff_ffff;
    endfunction

    initial begin
        repeat (20000) @(posedge I_CLK);
        err_count++;
        $display("BAD watchdog expected done seen hang");
        complete_run();
    end

    initial begin
        seed = 32'h616cb1bc;
        do_reset();
        foreach (regs[i]) rd(regs[i], 32'h0);
        foreach (regs[i]) begin
            d = $random(seed);
            wr(regs[i], d);
            rd(regs[i], d & rmask(regs[i]));
        end
        $display("test registers done");
        do_reset();
        d = $random(seed);
        wr(8'h18, d);
        @(posedge I_CLK);
        #1 chk_run(~d[7:0]);
        I_DBG_MODE <= 1'b1;
        repeat (2) @(posedge I_CLK);
        #1 chk_run(8'h00);
        I_DBG_MODE <= 1'b0;
        @(posedge I_CLK);
        #1 chk_run(~d[7:0]);
        wr(8'h18, 32'h0);
        $display("test core stop done");
        for (int k = 0; k < 4; k++) begin
            pc = $random(seed);
            d = $random(seed);
            c = d[2:0];
            wr(8'h30 + 8'(k), pc);
            wr(8'h40 + 8'(k), ctl(8'h01 << c, 1'b0, 1'b0, 1'b1));
            hit(3'h1, c, pc, 1'b0, 1'b1, hbw_pkg::CAUSE_IBRK, 2'(k));
            hit(3'h1, c + 3'h1, pc, 1'b0, 1'b0, 3'h0, 2'h0);
            hit(3'h1, c, pc ^ 32'h1, 1'b0, 1'b0, 3'h0, 2'h0);
            wr(8'h40 + 8'(k), ctl(8'h01 << c, 1'b0, 1'b1, 1'b1));
            hit(3'h1, c, pc ^ 32'h4, 1'b0, 1'b1, hbw_pkg::CAUSE_IBRK, 2'(k));
            hit(3'h1, c, pc, 1'b0, 1'b0, 3'h0, 2'h0);
            wr(8'h40 + 8'(k), ctl(8'h01 << c, 1'b0, 1'b0, 1'b0));
            hit(3'h1, c, pc, 1'b0, 1'b0, 3'h0, 2'h0);
        end
        $display("test instruction done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h52, (m == 3) ? 32'h1fff : 32'h1000);
            wr(8'h62, (m == 3) ? 32'h1000 : 32'h1fff);
            wr(8'h72, ctl(8'h20, m == 2, m == 3, 1'b1));
            for (int j = 0; j < 5; j++) begin
                hit(3'h2, 3'h5, da[j], m == 1 || m == 2, dexp[m][4-j],
                    hbw_pkg::CAUSE_DWATCH, 2'h2);
            end
        end
        wr(8'h72, 32'h0);
        $display("test data watch done");
        mk = $random(seed) | 32'h1;
        pc = $random(seed);
        c = pc[6:4];
        wr(8'h83, mk);
        wr(8'h93, pc & mk);
        wr(8'h9f, ctl(8'h01 << c, 1'b0, 1'b0, 1'b1));
        hit(3'h4, c, pc, 1'b0, 1'b1, hbw_pkg::CAUSE_RWATCH, 2'h3);
        hit(3'h4, c, pc ^ mk, 1'b0, 1'b0, 3'h0, 2'h0);
        hit(3'h4, c, pc ^ ~mk, 1'b0, 1'b1, hbw_pkg::CAUSE_RWATCH, 2'h3);
        wr(8'h9f, ctl(8'h01 << c, 1'b0, 1'b1, 1'b1));
        hit(3'h4, c, pc ^ mk, 1'b0, 1'b1, hbw_pkg::CAUSE_RWATCH, 2'h3);
        hit(3'h4, c, pc, 1'b0, 1'b0, 3'h0, 2'h0);
        wr(8'h9f, 32'h0);
        $display("test resource watch done");
        pc = $random(seed);
        foreach (regs[i]) if (i < 2) wr(8'h31 + 8'(i), pc);
        foreach (regs[i]) if (i < 2) wr(8'h41 + 8'(i), ctl(8'hff, 1'b0, 1'b0, 1'b1));
        foreach (regs[i]) if (i < 2) wr(8'h51 + 8'(2 * i), pc);
        foreach (regs[i]) if (i < 2) wr(8'h61 + 8'(2 * i), pc);
        foreach (regs[i]) if (i < 2) wr(8'h71 + 8'(2 * i), ctl(8'hff, 1'b0, 1'b0, 1'b1));
        hit(3'h3, 3'h0, pc, 1'b0, 1'b1, hbw_pkg::CAUSE_IBRK, 2'h1);
        wr(8'h41, 32'h0);
        wr(8'h42, 32'h0);
        hit(3'h3, 3'h7, pc, 1'b0, 1'b1, hbw_pkg::CAUSE_DWATCH, 2'h1);
        I_DBG_MODE <= 1'b1;
        hit(3'h3, 3'h7, pc, 1'b0, 1'b0, 3'h0, 2'h0);
        I_DBG_MODE <= 1'b0;
        $display("test priority done");
        repeat (4) @(posedge I_CLK);
        note("notes left", 40'h0, 40'(rq.size() + iq.size()));
        complete_run();
    end
endmodule
